// ### pll_loop_cfg_pkg.sv
`default_nettype none
package pll_loop_cfg_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_TRIM = 8'h00;
    localparam logic [7:0] OFS_HOLD = 8'h04;
    localparam logic [7:0] OFS_BW = 8'h08;
    localparam logic [7:0] OFS_DAMP = 8'h0C;
    localparam logic [7:0] OFS_MODE = 8'h10;
    localparam logic [7:0] OFS_LOCK_STS = 8'h14;
    localparam logic [7:0] OFS_INT_STS = 8'h18;
    localparam logic [7:0] OFS_INT_CLR = 8'h1C;
    localparam logic [7:0] OFS_INT_EN = 8'h20;
    // reset values
    localparam logic [15:0] RST_TRIM = 16'h0000;
    localparam logic [15:0] RST_HOLD = 16'h3800;
    localparam logic [15:0] RST_BW = 16'h7058;
    localparam logic [15:0] RST_DAMP = 16'h2901;
    localparam logic [15:0] RST_MODE = 16'h0080;
    // writable bits
    localparam logic [15:0] WM_TRIM = 16'h00FF;
    localparam logic [15:0] WM_HOLD = 16'hFFFF;
    localparam logic [15:0] WM_BW = 16'hFFFF;
    localparam logic [15:0] WM_DAMP = 16'h3F3F;
    localparam logic [15:0] WM_MODE = 16'h0088;
    // field positions
    localparam int TRIM_LSB = 0;
    localparam int TRIM_W = 8;
    localparam int HOLD_COARSE_LSB = 11;
    localparam int HOLD_FINE_LSB = 8;
    localparam int HISTORY_LSB = 4;
    localparam int LIMIT_LSB = 0;
    localparam int BW_LOCK_COARSE_LSB = 11;
    localparam int BW_LOCK_FINE_LSB = 8;
    localparam int BW_TRK_COARSE_LSB = 3;
    localparam int BW_TRK_FINE_LSB = 0;
    localparam int DAMP_LOCK_COARSE_LSB = 11;
    localparam int DAMP_LOCK_FINE_LSB = 8;
    localparam int DAMP_TRK_COARSE_LSB = 3;
    localparam int DAMP_TRK_FINE_LSB = 0;
    localparam int MODE_AUTO_SW_BIT = 7;
    localparam int MODE_UPD_HOLD_BIT = 3;
    localparam int COARSE_W = 5;
    localparam int FINE_W = 3;
    localparam int DCOARSE_W = 3;
    localparam int HISTORY_W = 4;
    localparam int LIMIT_W = 4;
    localparam int UNLOCK_CNT_W = 8;
    // limits
    localparam logic [4:0] HOLD_COARSE_MAX = 5'h14;
    localparam logic [3:0] HISTORY_MAX = 4'hA;
    // interrupt status bits
    localparam int EV_LIMIT_SET = 0;
    localparam int EV_LIMIT_CLR = 1;
    localparam int EV_UNGUARDED = 2;
    localparam int EV_W = 3;
endpackage
`default_nettype wire

// ### setting_select.sv
`timescale 1ns/100ps
`default_nettype none
module setting_select
    import pll_loop_cfg_pkg::*;
#(
    parameter int W = 3,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic use_lock,
    input wire logic [W-1:0] lock_value,
    input wire logic [W-1:0] track_value,
    output logic [W-1:0] active
);
    // registered pick between locking and tracking setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= RST;
        end else begin
            active <= use_lock ? lock_value : track_value;
        end
    end
endmodule
`default_nettype wire

// ### pll_loop_filter_config_bank.sv
// Functional notes
// - trim field is signed 8-bit offset, lsb 2^-20, applied as crystal compensation
// - holdover coarse field, reset 0x7; zero bypasses holdover filter
// - holdover coarse above 20 is used as 20; stored value unchanged
// - holdover fine field, reset zero; zero also bypasses holdover filter
// - unlock limit flag set while unlock count exceeds four-bit limit
// - locking coarse bandwidth, reset 0xE, used in acquire state
// - locking fine bandwidth, reset zero, used in acquire state
// - tracking coarse bandwidth, reset 0xB, used when locked
// - tracking fine bandwidth, reset zero, used when locked
// - locking coarse damping, reset 0x5, used in acquire state
// - locking fine damping, reset 0x1, used in acquire state
// - tracking coarse damping, reset zero, used when locked
// - tracking fine damping, reset 0x1, used when locked
// - locking settings apply only in acquire with auto switch set
`timescale 1ns/100ps
`default_nettype none
module pll_loop_filter_config_bank
    import pll_loop_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic loop_in_acquire,
    input wire logic loop_enabled,
    input wire logic [UNLOCK_CNT_W-1:0] unlock_count,
    output logic signed [TRIM_W-1:0] crystal_trim,
    output logic signed [20:0] crystal_comp_frac,
    output logic [COARSE_W-1:0] hold_filter_coarse,
    output logic [FINE_W-1:0] hold_filter_fine,
    output logic hold_filter_bypass,
    output logic [HISTORY_W-1:0] hold_history,
    output logic unlock_limit,
    output logic [COARSE_W-1:0] lock_phase_bandwidth_coarse,
    output logic [FINE_W-1:0] lock_phase_bandwidth_fine,
    output logic [COARSE_W-1:0] tracking_bandwidth_coarse,
    output logic [FINE_W-1:0] tracking_bandwidth_fine,
    output logic [DCOARSE_W-1:0] lock_phase_damping_coarse,
    output logic [FINE_W-1:0] lock_phase_damping_fine,
    output logic [DCOARSE_W-1:0] tracking_damping_coarse,
    output logic [FINE_W-1:0] tracking_damping_fine,
    output logic [COARSE_W-1:0] active_bandwidth_coarse,
    output logic [FINE_W-1:0] active_bandwidth_fine,
    output logic [DCOARSE_W-1:0] active_damping_coarse,
    output logic [FINE_W-1:0] active_damping_fine,
    output logic auto_setting_switch,
    output logic filter_update_hold,
    output logic irq
);
    logic [15:0] trim_reg;
    logic [15:0] hold_reg;
    logic [15:0] bw_reg;
    logic [15:0] damp_reg;
    logic [15:0] mode_reg;
    logic [EV_W-1:0] int_status;
    logic [EV_W-1:0] int_enable;
    logic [15:0] lane_mask;
    logic wr_access;
    logic rd_setup;
    logic mapped;
    logic [31:0] read_value;
    logic cfg_write;
    logic limit_prev;
    logic use_lock;
    logic next_limit;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic [COARSE_W-1:0] hold_coarse_raw;
    logic [HISTORY_W-1:0] history_raw;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wm,
                                          input logic [15:0] lanes, input logic [31:0] wd);
        logic [15:0] m;
        m = wm & lanes;
        merge = (old & ~m) | (wd[15:0] & m);
    endfunction

    // apb decode, zero wait states
    assign pready = 1'b1;
    assign wr_access = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        mapped = 1'b1;
        read_value = 32'h0000_0000;
        unique case (paddr)
            OFS_TRIM: read_value = {16'h0000, trim_reg};
            OFS_HOLD: read_value = {16'h0000, hold_reg};
            OFS_BW: read_value = {16'h0000, bw_reg};
            OFS_DAMP: read_value = {16'h0000, damp_reg};
            OFS_MODE: read_value = {16'h0000, mode_reg};
            OFS_LOCK_STS: read_value = {23'h000000, unlock_limit, unlock_count};
            OFS_INT_STS: read_value = {29'h00000000, int_status};
            OFS_INT_CLR: read_value = 32'h0000_0000;
            OFS_INT_EN: read_value = {29'h00000000, int_enable};
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~mapped;

    // read data is captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= read_value;
        end
    end

    // configuration registers, one process each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_reg <= RST_TRIM;
        end else if (wr_access && paddr == OFS_TRIM) begin
            trim_reg <= merge(trim_reg, WM_TRIM, lane_mask, pwdata);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= RST_HOLD;
        end else if (wr_access && paddr == OFS_HOLD) begin
            hold_reg <= merge(hold_reg, WM_HOLD, lane_mask, pwdata);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bw_reg <= RST_BW;
        end else if (wr_access && paddr == OFS_BW) begin
            bw_reg <= merge(bw_reg, WM_BW, lane_mask, pwdata);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            damp_reg <= RST_DAMP;
        end else if (wr_access && paddr == OFS_DAMP) begin
            damp_reg <= merge(damp_reg, WM_DAMP, lane_mask, pwdata);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= RST_MODE;
        end else if (wr_access && paddr == OFS_MODE) begin
            mode_reg <= merge(mode_reg, WM_MODE, lane_mask, pwdata);
        end
    end

    // interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_enable <= '0;
        end else if (wr_access && paddr == OFS_INT_EN && pstrb[0]) begin
            int_enable <= pwdata[EV_W-1:0];
        end
    end

    // stored fields as static outputs
    assign crystal_trim = trim_reg[TRIM_LSB +: TRIM_W];
    assign crystal_comp_frac = {{13{trim_reg[TRIM_W-1]}}, trim_reg[TRIM_LSB +: TRIM_W]};
    assign hold_coarse_raw = hold_reg[HOLD_COARSE_LSB +: COARSE_W];
    assign hold_filter_fine = hold_reg[HOLD_FINE_LSB +: FINE_W];
    assign history_raw = hold_reg[HISTORY_LSB +: HISTORY_W];
    assign lock_phase_bandwidth_coarse = bw_reg[BW_LOCK_COARSE_LSB +: COARSE_W];
    assign lock_phase_bandwidth_fine = bw_reg[BW_LOCK_FINE_LSB +: FINE_W];
    assign tracking_bandwidth_coarse = bw_reg[BW_TRK_COARSE_LSB +: COARSE_W];
    assign tracking_bandwidth_fine = bw_reg[BW_TRK_FINE_LSB +: FINE_W];
    assign lock_phase_damping_coarse = damp_reg[DAMP_LOCK_COARSE_LSB +: DCOARSE_W];
    assign lock_phase_damping_fine = damp_reg[DAMP_LOCK_FINE_LSB +: FINE_W];
    assign tracking_damping_coarse = damp_reg[DAMP_TRK_COARSE_LSB +: DCOARSE_W];
    assign tracking_damping_fine = damp_reg[DAMP_TRK_FINE_LSB +: FINE_W];
    assign auto_setting_switch = mode_reg[MODE_AUTO_SW_BIT];
    assign filter_update_hold = mode_reg[MODE_UPD_HOLD_BIT];

    // holdover coarse clamp and bypass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_filter_coarse <= RST_HOLD[HOLD_COARSE_LSB +: COARSE_W];
            hold_filter_bypass <= 1'b1;
            hold_history <= '0;
        end else begin
            hold_filter_coarse <= (hold_coarse_raw > HOLD_COARSE_MAX) ? HOLD_COARSE_MAX : hold_coarse_raw;
            hold_filter_bypass <= (hold_coarse_raw == '0) || (hold_filter_fine == '0);
            hold_history <= (history_raw > HISTORY_MAX) ? HISTORY_MAX : history_raw;
        end
    end

    // loss of lock limit flag
    assign next_limit = unlock_count > {{(UNLOCK_CNT_W-LIMIT_W){1'b0}}, hold_reg[LIMIT_LSB +: LIMIT_W]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_limit <= 1'b0;
        end else begin
            unlock_limit <= next_limit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_prev <= 1'b0;
        end else begin
            limit_prev <= unlock_limit;
        end
    end

    // locking or tracking selection
    assign use_lock = loop_in_acquire & auto_setting_switch;

    setting_select #(.W(COARSE_W), .RST(RST_BW[BW_TRK_COARSE_LSB +: COARSE_W])) u_sel_bw_coarse (
        .pclk(pclk),
        .presetn(presetn),
        .use_lock(use_lock),
        .lock_value(lock_phase_bandwidth_coarse),
        .track_value(tracking_bandwidth_coarse),
        .active(active_bandwidth_coarse)
    );
    setting_select #(.W(FINE_W), .RST(RST_BW[BW_TRK_FINE_LSB +: FINE_W])) u_sel_bw_fine (
        .pclk(pclk),
        .presetn(presetn),
        .use_lock(use_lock),
        .lock_value(lock_phase_bandwidth_fine),
        .track_value(tracking_bandwidth_fine),
        .active(active_bandwidth_fine)
    );
    setting_select #(.W(DCOARSE_W), .RST(RST_DAMP[DAMP_TRK_COARSE_LSB +: DCOARSE_W])) u_sel_damp_coarse (
        .pclk(pclk),
        .presetn(presetn),
        .use_lock(use_lock),
        .lock_value(lock_phase_damping_coarse),
        .track_value(tracking_damping_coarse),
        .active(active_damping_coarse)
    );
    setting_select #(.W(FINE_W), .RST(RST_DAMP[DAMP_TRK_FINE_LSB +: FINE_W])) u_sel_damp_fine (
        .pclk(pclk),
        .presetn(presetn),
        .use_lock(use_lock),
        .lock_value(lock_phase_damping_fine),
        .track_value(tracking_damping_fine),
        .active(active_damping_fine)
    );

    // events: limit rise, limit fall, config write without update hold
    assign cfg_write = wr_access && (paddr == OFS_TRIM || paddr == OFS_HOLD || paddr == OFS_BW || paddr == OFS_DAMP);
    always_comb begin
        ev_set = '0;
        ev_set[EV_LIMIT_SET] = unlock_limit & ~limit_prev;
        ev_set[EV_LIMIT_CLR] = ~unlock_limit & limit_prev;
        ev_set[EV_UNGUARDED] = cfg_write & loop_enabled & ~filter_update_hold;
    end
    assign ev_clr = (wr_access && paddr == OFS_INT_CLR && pstrb[0]) ? pwdata[EV_W-1:0] : '0;

    // sticky status, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= '0;
        end else begin
            int_status <= (int_status & ~ev_clr) | ev_set;
        end
    end

    assign irq = |(int_status & int_enable);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_coarse_clamp: assert property (hold_coarse_raw > 5'd20 |=> hold_filter_coarse == 5'd20)
        else $error("holdover coarse not clamped to 20");
    chk_coarse_pass: assert property (hold_coarse_raw <= 5'd20 |=> hold_filter_coarse == $past(hold_coarse_raw))
        else $error("holdover coarse altered below limit");
    chk_hold_bypass: assert property (hold_filter_fine == 3'd0 |=> hold_filter_bypass)
        else $error("holdover bypass missing with zero fine");
    chk_limit_flag: assert property (##1 unlock_limit == ($past(unlock_count) > {4'h0, $past(hold_reg[3:0])}))
        else $error("unlock limit flag mismatch");
    chk_history_range: assert property (hold_history <= 4'hA)
        else $error("history beyond ten seconds");
    chk_lock_select: assert property (loop_in_acquire && auto_setting_switch |=>
        active_bandwidth_coarse == $past(bw_reg[15:11]) && active_bandwidth_fine == $past(bw_reg[10:8]))
        else $error("locking bandwidth not applied");
    chk_track_select: assert property (!(loop_in_acquire && auto_setting_switch) |=>
        active_damping_coarse == $past(damp_reg[5:3]) && active_damping_fine == $past(damp_reg[2:0]))
        else $error("tracking damping not applied");
    chk_unguarded_evt: assert property (cfg_write && loop_enabled && !filter_update_hold |=>
        int_status[EV_UNGUARDED] [*2])
        else $error("unguarded write not flagged");
    chk_damp_reserved: assert property (damp_reg[15:14] == 2'b00 && damp_reg[7:6] == 2'b00)
        else $error("damping reserved bits set");
    chk_trim_sign: assert property (crystal_comp_frac[20:7] == {14{crystal_trim[7]}})
        else $error("trim sign extension wrong");
    chk_lock_damp: assert property (loop_in_acquire && auto_setting_switch |=>
        active_damping_coarse == $past(damp_reg[13:11]) && active_damping_fine == $past(damp_reg[10:8]))
        else $error("locking damping not applied");
    chk_track_bw: assert property (!(loop_in_acquire && auto_setting_switch) |=>
        active_bandwidth_coarse == $past(bw_reg[7:3]) && active_bandwidth_fine == $past(bw_reg[2:0]))
        else $error("tracking bandwidth not applied");
    chk_bypass_exact: assert property (##1 hold_filter_bypass ==
        ($past(hold_coarse_raw) == 5'h00 || $past(hold_filter_fine) == 3'h0))
        else $error("holdover bypass wrong");
    chk_coarse_zero: assert property (hold_coarse_raw == 5'h00 |=> hold_filter_bypass)
        else $error("holdover bypass missing with zero coarse");
    chk_history_clamp: assert property (history_raw > HISTORY_MAX |=> hold_history == HISTORY_MAX)
        else $error("history code not limited");
    chk_history_pass: assert property (history_raw <= HISTORY_MAX |=> hold_history == $past(history_raw))
        else $error("history code altered");
    chk_limit_clear: assert property (unlock_count <= {4'h0, hold_reg[3:0]} |=> !unlock_limit)
        else $error("unlock limit flag not cleared");
    chk_limit_set: assert property (unlock_count > {4'h0, hold_reg[3:0]} |=> unlock_limit)
        else $error("unlock limit flag not set");
    chk_bw_write: assert property (wr_access && paddr == OFS_BW && pstrb[1:0] == 2'b11 |=>
        bw_reg == $past(pwdata[15:0]))
        else $error("bandwidth write lost");
    chk_hold_write: assert property (wr_access && paddr == OFS_HOLD && pstrb[1:0] == 2'b11 |=>
        hold_reg == $past(pwdata[15:0]))
        else $error("holdover write lost");
    chk_trim_reserved: assert property (trim_reg[15:8] == 8'h00)
        else $error("trim reserved bits set");
    chk_mode_reserved: assert property ((mode_reg & ~WM_MODE) == 16'h0000)
        else $error("mode reserved bits set");
    chk_status_sticky: assert property (int_status[EV_LIMIT_SET] && !ev_clr[EV_LIMIT_SET] |=>
        int_status[EV_LIMIT_SET])
        else $error("status bit lost without clear");
    chk_set_wins: assert property (ev_set[EV_LIMIT_CLR] |=> int_status[EV_LIMIT_CLR])
        else $error("status event not latched");
    chk_irq_level: assert property (irq == |(int_status & int_enable))
        else $error("interrupt level wrong");
    chk_read_capture: assert property (psel && !penable && !pwrite |=> prdata == $past(read_value))
        else $error("read data not captured");
    chk_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access without error");
    chk_status_clear: assert property (ev_clr[EV_UNGUARDED] && !ev_set[EV_UNGUARDED] |=> !int_status[EV_UNGUARDED])
        else $error("status bit not cleared");
endmodule
`default_nettype wire

// ### pll_loop_filter_config_bank_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pll_loop_filter_config_bank_tb_top;
    import pll_loop_cfg_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic loop_in_acquire = 1'b0, loop_enabled = 1'b0;
    logic [7:0] unlock_count = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, hold_filter_bypass, unlock_limit, auto_setting_switch, filter_update_hold, irq;
    logic signed [7:0] crystal_trim;
    logic signed [20:0] crystal_comp_frac;
    logic [4:0] hold_filter_coarse, lock_phase_bandwidth_coarse, tracking_bandwidth_coarse, active_bandwidth_coarse;
    logic [2:0] hold_filter_fine, lock_phase_bandwidth_fine, tracking_bandwidth_fine, active_bandwidth_fine;
    logic [2:0] lock_phase_damping_coarse, lock_phase_damping_fine, tracking_damping_coarse, tracking_damping_fine;
    logic [2:0] active_damping_coarse, active_damping_fine;
    logic [3:0] hold_history;
    int n_fail = 0;
    int n_tests = 0;
    logic [15:0] m [5];
    logic [15:0] wmask [5] = '{WM_TRIM, WM_HOLD, WM_BW, WM_DAMP, WM_MODE};
    logic [15:0] rstv [5] = '{RST_TRIM, RST_HOLD, RST_BW, RST_DAMP, RST_MODE};
    logic [15:0] hv [4] = '{16'hA8F5, 16'hF9A3, 16'h0100, 16'h0817};
    logic [31:0] rd, v;
    logic er;
    int k;

    pll_loop_filter_config_bank i_pll_loop_filter_config_bank (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .loop_in_acquire, .loop_enabled, .unlock_count, .crystal_trim, .crystal_comp_frac,
        .hold_filter_coarse, .hold_filter_fine, .hold_filter_bypass, .hold_history, .unlock_limit,
        .lock_phase_bandwidth_coarse, .lock_phase_bandwidth_fine, .tracking_bandwidth_coarse,
        .tracking_bandwidth_fine, .lock_phase_damping_coarse, .lock_phase_damping_fine,
        .tracking_damping_coarse, .tracking_damping_fine, .active_bandwidth_coarse, .active_bandwidth_fine,
        .active_damping_coarse, .active_damping_fine, .auto_setting_switch, .filter_update_hold, .irq
    );

    always #5 pclk = ~pclk;

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && i < 100) begin
            @(posedge pclk);
            i++;
        end
        if (i == 100) n_fail++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [15:0] lm;
        apb(1'b1, a, d);
        if (a <= OFS_MODE) begin
            lm = {{8{pstrb[1]}}, {8{pstrb[0]}}} & wmask[a[4:2]];
            m[a[4:2]] = (m[a[4:2]] & ~lm) | (d[15:0] & lm);
        end
    endtask

    task drive(input logic acq, input logic [7:0] cnt);
        @(posedge pclk);
        loop_in_acquire <= acq;
        unlock_count <= cnt;
    endtask

    task outs;
        logic [4:0] hc;
        logic acq;
        repeat (3) @(posedge pclk);
        #1;
        hc = (m[1][15:11] > 5'd20) ? 5'd20 : m[1][15:11];
        acq = loop_in_acquire & m[4][7];
        chk($unsigned(crystal_trim), m[0][7:0]);
        chk($unsigned(crystal_comp_frac), {{13{m[0][7]}}, m[0][7:0]});
        chk(hold_filter_coarse, hc);
        chk(hold_filter_fine, m[1][10:8]);
        chk(hold_filter_bypass, hc == 5'd0 || m[1][10:8] == 3'd0);
        chk(hold_history, (m[1][7:4] > 4'hA) ? 4'hA : m[1][7:4]);
        chk(unlock_limit, unlock_count > {4'h0, m[1][3:0]});
        chk({lock_phase_bandwidth_coarse, lock_phase_bandwidth_fine, tracking_bandwidth_coarse,
            tracking_bandwidth_fine}, m[2]);
        chk({2'b00, lock_phase_damping_coarse, lock_phase_damping_fine, 2'b00, tracking_damping_coarse,
            tracking_damping_fine}, m[3]);
        chk({active_bandwidth_coarse, active_bandwidth_fine}, acq ? m[2][15:8] : m[2][7:0]);
        chk({active_damping_coarse, active_damping_fine}, acq ? m[3][13:8] : m[3][5:0]);
        chk({auto_setting_switch, filter_update_hold}, {m[4][7], m[4][3]});
    endtask

    task ick(input logic [2:0] s, input logic q);
        apb(1'b0, OFS_INT_STS, 32'h0);
        chk(rd, {29'h0, s});
        @(posedge pclk);
        #1;
        chk(irq, q);
    endtask

    initial begin
        #500000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(58618));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 5; k++) m[k] = rstv[k];
        for (k = 0; k < 5; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk(rd, {16'h0, rstv[k]});
        end
        outs();
        chk(irq, 1'b0);
        foreach (hv[j]) begin
            wr(OFS_HOLD, {16'h0, hv[j]});
            drive(1'b0, {4'h0, hv[j][3:0]});
            outs();
            drive(1'b0, {4'h0, hv[j][3:0]} + 8'h01);
            outs();
            apb(1'b0, OFS_HOLD, 32'h0);
            chk(rd, {16'h0, hv[j]});
        end
        for (k = 0; k < 4; k++) begin
            wr(OFS_MODE, {24'h0, k[1], 7'h0});
            drive(k[0], 8'h00);
            outs();
        end
        repeat (40) begin
            k = $urandom_range(4);
            v = $urandom;
            @(posedge pclk);
            pstrb <= 4'($urandom);
            wr(8'(k * 4), v);
            drive(1'($urandom), 8'($urandom_range(20)));
            apb(1'b0, 8'(k * 4), 32'h0);
            chk(rd, {16'h0, m[k]});
            outs();
        end
        @(posedge pclk);
        pstrb <= 4'hF;
        apb(1'b0, 8'h24, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        chk(pready, 1'b1);
        apb(1'b1, OFS_LOCK_STS, 32'hFFFF);
        chk(er, 1'b0);
        apb(1'b0, OFS_LOCK_STS, 32'h0);
        chk(rd, {23'h0, unlock_count > {4'h0, m[1][3:0]}, unlock_count});
        wr(OFS_HOLD, 32'h3804);
        drive(1'b0, 8'h00);
        wr(OFS_INT_CLR, 32'h7);
        wr(OFS_INT_EN, 32'h7);
        ick(3'h0, 1'b0);
        drive(1'b0, 8'h05);
        outs();
        ick(3'h1, 1'b1);
        drive(1'b0, 8'h04);
        outs();
        ick(3'h3, 1'b1);
        wr(OFS_INT_EN, 32'h0);
        ick(3'h3, 1'b0);
        wr(OFS_INT_CLR, 32'h3);
        wr(OFS_INT_EN, 32'h4);
        ick(3'h0, 1'b0);
        @(posedge pclk);
        loop_enabled <= 1'b1;
        wr(OFS_MODE, 32'h88);
        wr(OFS_BW, 32'h1234);
        wr(OFS_MODE, 32'h80);
        ick(3'h0, 1'b0);
        wr(OFS_TRIM, 32'h80);
        ick(3'h4, 1'b1);
        outs();
        wr(OFS_INT_CLR, 32'h4);
        ick(3'h0, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
